/* rtl/mie_irq_ctrl.sv */
// interrupt enable, flag and priority registers with request selection
`timescale 1ns/10ps
module mie_irq_ctrl (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [mie_pkg::SFR_AW-1:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic [mie_pkg::SFR_DW-1:0] sfr_wdata_in,
   output logic [mie_pkg::SFR_DW-1:0] sfr_rdata_out,
   input wire logic uart1_tx_done_in,
   input wire logic uart1_rx_done_in,
   input wire logic timer2_overflow_in,
   input wire logic timer2_external_flag_in,
   input wire logic timer1_overflow_in,
   input wire logic timer0_overflow_in,
   input wire logic pin_irq1_input_in,
   input wire logic pin_irq0_input_in,
   input wire logic pin_irq1_edge_mode_in,
   input wire logic pin_irq0_edge_mode_in,
   input wire logic [3:0] ext_irq_trigger_in,
   input wire logic powerdown_trigger_in,
   input wire logic insn_done_in,
   input wire logic vector_ack_in,
   input wire logic reti_in,
   output logic irq_req_out,
   output logic [mie_pkg::SRC_W-1:0] irq_num_out,
   output logic irq_level_out,
   output logic uart1_baud_double_out
);
   import mie_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] irq_enable_main;
   logic [7:0] irq_priority_main;
   logic [4:0] irq_enable_extended;
   logic [3:0] extended_irq_flags;
   logic powerdown_flag;
   logic uart1_baud_double;
   logic [1:0] in_service;
   logic [1:0] holdoff_cnt;
   logic [1:0] pin_flag;
   logic [1:0] pin_clear;
   logic [1:0] pin_level;
   logic [1:0] pin_edge_mode;
   logic [NUM_SRC-1:0] src_flag;
   logic [NUM_SRC-1:0] src_enable;
   logic [NUM_SRC-1:0] src_prio;
   logic [NUM_SRC-1:0] src_req;
   logic next_req;
   logic [SRC_W-1:0] next_num;
   logic next_level;
   logic found_hi;
   logic found_lo;
   logic [SRC_W-1:0] num_hi;
   logic [SRC_W-1:0] num_lo;
   logic [7:0] next_rdata;
   logic wr_main;
   logic wr_prio;
   logic wr_ext_en;
   logic wr_flags;
   logic wr_ctrl;
   logic holdoff_load;

   always_comb begin
      wr_main = sfr_wr_in && (sfr_addr_in == ADDR_ENABLE_MAIN);
      wr_prio = sfr_wr_in && (sfr_addr_in == ADDR_PRIO_MAIN);
      wr_ext_en = sfr_wr_in && (sfr_addr_in == ADDR_ENABLE_EXT);
      wr_flags = sfr_wr_in && (sfr_addr_in == ADDR_EXT_FLAGS);
      wr_ctrl = sfr_wr_in && (sfr_addr_in == ADDR_EXT_CONTROL);
      // the writing instruction itself blocks vectoring in its own cycle
      holdoff_load = wr_main || wr_prio || wr_ext_en || reti_in;
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_enable_main <= RST_ENABLE_MAIN;
      end else if (wr_main) begin
         irq_enable_main <= sfr_wdata_in & MASK_ENABLE_MAIN;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_priority_main <= RST_PRIO_MAIN;
      end else if (wr_prio) begin
         irq_priority_main <= sfr_wdata_in & MASK_PRIO_MAIN;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_enable_extended <= RST_ENABLE_EXT;
      end else if (wr_ext_en) begin
         irq_enable_extended <= sfr_wdata_in[4:0];
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         extended_irq_flags <= RST_EXT_FLAGS;
      end else if (wr_flags) begin
         extended_irq_flags <= sfr_wdata_in[7:EXT_FLAG_LSB] | ext_irq_trigger_in;
      end else begin
         extended_irq_flags <= extended_irq_flags | ext_irq_trigger_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         powerdown_flag <= 1'b0;
         uart1_baud_double <= 1'b0;
      end else if (wr_ctrl) begin
         powerdown_flag <= sfr_wdata_in[BIT_POWERDOWN] | powerdown_trigger_in;
         uart1_baud_double <= sfr_wdata_in[BIT_BAUD_DOUBLE];
      end else begin
         powerdown_flag <= powerdown_flag | powerdown_trigger_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // external pin detection
   assign pin_level = {pin_irq1_input_in, pin_irq0_input_in};
   assign pin_edge_mode = {pin_irq1_edge_mode_in, pin_irq0_edge_mode_in};
   assign pin_clear[0] = vector_ack_in && (irq_num_out == SRC_W'(SRC_PIN0));
   assign pin_clear[1] = vector_ack_in && (irq_num_out == SRC_W'(SRC_PIN1));

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         mie_pin_detect u_detect (
            .clock_in(clock_in),
            .rst_n_in(rst_n_in),
            .pin_in(pin_level[gi]),
            .edge_mode_in(pin_edge_mode[gi]),
            .clear_in(pin_clear[gi]),
            .flag_out(pin_flag[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // per-source flag, enable and priority vectors
   always_comb begin
      src_flag = '0;
      src_enable = '0;
      src_prio = '0;
      src_flag[SRC_PIN0] = pin_flag[0];
      src_flag[SRC_TIMER0] = timer0_overflow_in;
      src_flag[SRC_PIN1] = pin_flag[1];
      src_flag[SRC_TIMER1] = timer1_overflow_in;
      src_flag[SRC_TIMER2] = timer2_overflow_in | timer2_external_flag_in;
      src_flag[SRC_UART1] = uart1_tx_done_in | uart1_rx_done_in;
      src_flag[SRC_IRQ8 +: 4] = extended_irq_flags;
      src_flag[SRC_POWERDOWN] = powerdown_flag;
      src_enable[SRC_PIN0] = irq_enable_main[BIT_PIN0];
      src_enable[SRC_TIMER0] = irq_enable_main[BIT_TIMER0];
      src_enable[SRC_PIN1] = irq_enable_main[BIT_PIN1];
      src_enable[SRC_TIMER1] = irq_enable_main[BIT_TIMER1];
      src_enable[SRC_TIMER2] = irq_enable_main[BIT_TIMER2];
      src_enable[SRC_UART1] = irq_enable_main[BIT_UART1];
      src_enable[SRC_IRQ8 +: 5] = irq_enable_extended;
      src_prio[SRC_PIN0] = irq_priority_main[BIT_PIN0];
      src_prio[SRC_TIMER0] = irq_priority_main[BIT_TIMER0];
      src_prio[SRC_PIN1] = irq_priority_main[BIT_PIN1];
      src_prio[SRC_TIMER1] = irq_priority_main[BIT_TIMER1];
      src_prio[SRC_TIMER2] = irq_priority_main[BIT_TIMER2];
      src_prio[SRC_UART1] = irq_priority_main[BIT_UART1];
   end

   // flag, own enable and global enable all needed
   assign src_req = src_flag & src_enable & {NUM_SRC{irq_enable_main[BIT_GLOBAL_ON]}};

   ////////////////////////////////////////////////////////////////////////////
   // selection: lowest number wins within a level
   always_comb begin
      found_hi = 1'b0;
      found_lo = 1'b0;
      num_hi = '0;
      num_lo = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (src_req[i] && src_prio[i]) begin
            found_hi = 1'b1;
            num_hi = SRC_W'(i);
         end
         if (src_req[i] && !src_prio[i]) begin
            found_lo = 1'b1;
            num_lo = SRC_W'(i);
         end
      end
   end

   // level 1 preempts level 0; nothing preempts level 1
   always_comb begin
      next_req = 1'b0;
      next_num = '0;
      next_level = 1'b0;
      if (holdoff_cnt != 2'h0 || holdoff_load || in_service[1]) begin
         next_req = 1'b0;
      end else if (found_hi) begin
         next_req = 1'b1;
         next_num = num_hi;
         next_level = 1'b1;
      end else if (found_lo && !in_service[0]) begin
         next_req = 1'b1;
         next_num = num_lo;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_req_out <= 1'b0;
         irq_num_out <= '0;
         irq_level_out <= 1'b0;
      end else begin
         irq_req_out <= next_req & ~vector_ack_in;
         irq_num_out <= next_num;
         irq_level_out <= next_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // service level tracking
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         in_service <= 2'b00;
      end else if (vector_ack_in && irq_req_out) begin
         in_service[irq_level_out] <= 1'b1;
      end else if (reti_in) begin
         if (in_service[1]) begin
            in_service[1] <= 1'b0;
         end else begin
            in_service[0] <= 1'b0;
         end
      end
   end

   // an enable or priority write or a return lets two further instructions finish first
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         holdoff_cnt <= 2'h0;
      end else if (holdoff_load) begin
         holdoff_cnt <= HOLDOFF_INSNS;
      end else if (insn_done_in && holdoff_cnt != 2'h0) begin
         holdoff_cnt <= holdoff_cnt - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read-back
   always_comb begin
      if (sfr_addr_in == ADDR_ENABLE_MAIN) begin
         next_rdata = irq_enable_main;
      end else if (sfr_addr_in == ADDR_PRIO_MAIN) begin
         next_rdata = irq_priority_main | ONES_PRIO_MAIN;
      end else if (sfr_addr_in == ADDR_ENABLE_EXT) begin
         next_rdata = ONES_ENABLE_EXT | {3'h0, irq_enable_extended};
      end else if (sfr_addr_in == ADDR_EXT_FLAGS) begin
         next_rdata = ONES_EXT_FLAGS | {extended_irq_flags, 4'h0};
      end else if (sfr_addr_in == ADDR_EXT_CONTROL) begin
         next_rdata = ONES_EXT_CONTROL | {uart1_baud_double, 3'h0, powerdown_flag, 3'h0};
      end else begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sfr_rdata_out <= 8'h00;
         uart1_baud_double_out <= 1'b0;
      end else begin
         sfr_rdata_out <= next_rdata;
         uart1_baud_double_out <= uart1_baud_double;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_global_gate_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      !irq_enable_main[BIT_GLOBAL_ON] |=> !irq_req_out)
      else $error("request while global enable off");

   a_ext_reads_ones: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      sfr_addr_in == ADDR_ENABLE_EXT |=> sfr_rdata_out[7:5] == 3'h7)
      else $error("extended enable reserved bits not ones");

   a_flag_hw_set: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      ext_irq_trigger_in[0] |=> extended_irq_flags[0])
      else $error("hardware trigger lost");

   a_flag_sticky: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      extended_irq_flags[3] && !wr_flags |=> extended_irq_flags[3])
      else $error("extended flag cleared without write");

   a_sw_flag_raise: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      wr_flags && sfr_wdata_in[EXT_FLAG_LSB] |=> extended_irq_flags[0])
      else $error("software flag set not taken");

   a_pd_sticky: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      powerdown_flag && !wr_ctrl |=> powerdown_flag)
      else $error("powerdown flag dropped alone");

   a_pd_raise: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      wr_ctrl && sfr_wdata_in[BIT_POWERDOWN] |=> powerdown_flag)
      else $error("powerdown software set not taken");

   a_baud_follow: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      wr_ctrl |-> ##2 uart1_baud_double_out == $past(sfr_wdata_in[BIT_BAUD_DOUBLE], 2))
      else $error("baud double output wrong");

   a_no_lo_preempt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      in_service[1] |=> !irq_req_out)
      else $error("request during level 1 service");

   a_holdoff_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      wr_main |=> !irq_req_out ##1 !irq_req_out)
      else $error("request too soon after enable write");

   a_reti_holdoff: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      reti_in |=> !irq_req_out ##1 !irq_req_out)
      else $error("request too soon after return");

   a_req_enabled: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      irq_req_out |-> $past(src_flag[next_num] && src_enable[next_num]
         && irq_enable_main[BIT_GLOBAL_ON]))
      else $error("request for disabled source");
endmodule

/* include/mie_pkg.sv */
// constants for the interrupt enable, flag and priority block
package mie_pkg;
   localparam int SFR_AW = 8;
   localparam int SFR_DW = 8;
   localparam int NUM_SRC = 13;
   localparam int SRC_W = 4;
   // register addresses
   localparam logic [7:0] ADDR_EXT_FLAGS = 8'h91;
   localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8;
   localparam logic [7:0] ADDR_PRIO_MAIN = 8'hB8;
   localparam logic [7:0] ADDR_EXT_CONTROL = 8'hD8;
   localparam logic [7:0] ADDR_ENABLE_EXT = 8'hE8;
   // main enable field positions
   localparam int BIT_GLOBAL_ON = 7;
   localparam int BIT_UART1 = 6;
   localparam int BIT_TIMER2 = 5;
   localparam int BIT_TIMER1 = 3;
   localparam int BIT_PIN1 = 2;
   localparam int BIT_TIMER0 = 1;
   localparam int BIT_PIN0 = 0;
   // extended control field positions
   localparam int BIT_BAUD_DOUBLE = 7;
   localparam int BIT_POWERDOWN = 3;
   // extended flag field: irq8..irq11 at bits 4..7
   localparam int EXT_FLAG_LSB = 4;
   // reset values
   localparam logic [7:0] RST_ENABLE_MAIN = 8'h00;
   localparam logic [7:0] RST_PRIO_MAIN = 8'h00;
   localparam logic [4:0] RST_ENABLE_EXT = 5'h00;
   localparam logic [3:0] RST_EXT_FLAGS = 4'h0;
   // write masks and read-back ones for reserved bits
   localparam logic [7:0] MASK_ENABLE_MAIN = 8'hEF;
   localparam logic [7:0] MASK_PRIO_MAIN = 8'h6F;
   localparam logic [7:0] ONES_PRIO_MAIN = 8'h80;
   localparam logic [7:0] ONES_ENABLE_EXT = 8'hE0;
   localparam logic [7:0] ONES_EXT_FLAGS = 8'h08;
   localparam logic [7:0] ONES_EXT_CONTROL = 8'h40;
   // interrupt numbers in polling order
   localparam int SRC_PIN0 = 0;
   localparam int SRC_TIMER0 = 1;
   localparam int SRC_PIN1 = 2;
   localparam int SRC_TIMER1 = 3;
   localparam int SRC_TIMER2 = 5;
   localparam int SRC_UART1 = 6;
   localparam int SRC_IRQ8 = 8;
   localparam int SRC_POWERDOWN = 12;
   // instructions to finish after an enable or priority write
   localparam logic [1:0] HOLDOFF_INSNS = 2'h2;
endpackage

/* rtl/mie_pin_detect.sv */
// falling-edge or low-level detector for one external interrupt pin
`timescale 1ns/10ps
module mie_pin_detect (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   input wire logic edge_mode_in,
   input wire logic clear_in,
   output logic flag_out
);
   logic pin_prev;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         pin_prev <= 1'b1;
      end else begin
         pin_prev <= pin_in;
      end
   end

   // edge mode latches until vectored; level mode follows the pin
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         flag_out <= 1'b0;
      end else if (!edge_mode_in) begin
         flag_out <= ~pin_in;
      end else if (pin_prev && !pin_in) begin
         flag_out <= 1'b1;
      end else if (clear_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule

/* bench/mie_core_model.sv */
// core sequencer model: instruction ticks, vector acknowledge, return
`timescale 1ns/10ps
module mie_core_model #(
   parameter int GAP = 3
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic irq_req_in,
   input wire logic run_in,
   input wire logic ack_on_in,
   input wire logic reti_go_in,
   output logic insn_done_out,
   output logic vector_ack_out,
   output logic reti_out
);
   int cnt;
   int depth;
   ////////////////////////////////////////////////////////////////
   // instruction completion ticks, paused when run is low
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         cnt <= 0;
         insn_done_out <= 1'b0;
      end else begin
         cnt <= (cnt >= GAP - 1) ? 0 : cnt + 1;
         insn_done_out <= run_in && (cnt == 0);
      end
   end
   ////////////////////////////////////////////////////////////////
   // one ack per request, one return per ack
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         vector_ack_out <= 1'b0;
         reti_out <= 1'b0;
         depth <= 0;
      end else begin
         vector_ack_out <= ack_on_in && irq_req_in && !vector_ack_out;
         reti_out <= reti_go_in && (depth > 0) && !reti_out;
         depth <= depth + int'(vector_ack_out) - int'(reti_out);
      end
   end
endmodule

/* bench/test_mie_irq_ctrl.sv */
// self-checking bench for the interrupt enable, flag and priority block
`timescale 1ns/10ps
module test_mie_irq_ctrl;
   import mie_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic w;
      logic [7:0] d;
      logic [7:0] r;
      logic b;
   } mie_row_s;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic u1tx = 1'b0, u1rx = 1'b0, t2ov = 1'b0, t2ex = 1'b0, t1ov = 1'b0, t0ov = 1'b0;
   logic pin1 = 1'b1, pin0 = 1'b1, edge1 = 1'b0, edge0 = 1'b0;
   logic [3:0] ext_trig = 4'h0;
   logic pd_trig = 1'b0, run = 1'b1, ack_on = 1'b0, reti_go = 1'b0;
   logic insn_done, vack, reti, req, lvl, baud;
   logic [3:0] num;
   logic [7:0] rdata;
   int fails = 0;
   int n_tests = 0;
   int srcs [6] = '{0, 1, 2, 3, 5, 6};
   mie_row_s rows [16] = '{
      {8'hA8, 1'b0, 8'h00, 8'h00, 1'b0}, {8'hB8, 1'b0, 8'h00, 8'h80, 1'b0},
      {8'hE8, 1'b0, 8'h00, 8'hE0, 1'b0}, {8'h91, 1'b0, 8'h00, 8'h08, 1'b0},
      {8'hD8, 1'b0, 8'h00, 8'h40, 1'b0}, {8'hA8, 1'b1, 8'hFF, 8'hEF, 1'b0},
      {8'hA8, 1'b1, 8'h00, 8'h00, 1'b0}, {8'hB8, 1'b1, 8'hFF, 8'hEF, 1'b0},
      {8'hB8, 1'b1, 8'h00, 8'h80, 1'b0}, {8'hE8, 1'b1, 8'h1F, 8'hFF, 1'b0},
      {8'hE8, 1'b1, 8'h00, 8'hE0, 1'b0}, {8'hD8, 1'b1, 8'hFF, 8'hC8, 1'b1},
      {8'hD8, 1'b1, 8'h00, 8'h40, 1'b0}, {8'h91, 1'b1, 8'hF0, 8'hF8, 1'b0},
      {8'h91, 1'b1, 8'h00, 8'h08, 1'b0}, {8'h92, 1'b1, 8'hFF, 8'h00, 1'b0}};
   ////////////////////////////////////////////////////////////////
   mie_irq_ctrl DUT (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .sfr_addr_in(addr), .sfr_wr_in(sfr_wr),
      .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .uart1_tx_done_in(u1tx),
      .uart1_rx_done_in(u1rx), .timer2_overflow_in(t2ov), .timer2_external_flag_in(t2ex),
      .timer1_overflow_in(t1ov), .timer0_overflow_in(t0ov), .pin_irq1_input_in(pin1),
      .pin_irq0_input_in(pin0), .pin_irq1_edge_mode_in(edge1), .pin_irq0_edge_mode_in(edge0),
      .ext_irq_trigger_in(ext_trig), .powerdown_trigger_in(pd_trig), .insn_done_in(insn_done),
      .vector_ack_in(vack), .reti_in(reti), .irq_req_out(req), .irq_num_out(num),
      .irq_level_out(lvl), .uart1_baud_double_out(baud));
   mie_core_model core (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .irq_req_in(req), .run_in(run),
      .ack_on_in(ack_on), .reti_go_in(reti_go), .insn_done_out(insn_done),
      .vector_ack_out(vack), .reti_out(reti));
   ////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock_in);
      sfr_wr <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_in);
      addr <= a;
      repeat (2) @(posedge clock_in);
      #1 check("rdata", e, rdata);
   endtask
   task automatic no_req(input int n);
      repeat (n) begin
         @(posedge clock_in);
         #1 check("idle req", 8'h00, {7'h00, req});
      end
   endtask
   task automatic take(input logic [3:0] n, input logic l);
      int i;
      logic hung;
      #1;
      for (i = 0; i < 60 && req !== 1'b1; i++) @(posedge clock_in) #1;
      check("req", 8'h01, {7'h00, req});
      hung = (req !== 1'b1);
      if (!hung) begin
         check("num", {4'h0, n}, {4'h0, num});
         check("level", {7'h00, l}, {7'h00, lvl});
         @(posedge clock_in);
         ack_on <= 1'b1;
         for (i = 0; i < 20 && req !== 1'b0; i++) @(posedge clock_in) #1;
         check("req drop", 8'h00, {7'h00, req});
         hung = (req !== 1'b0);
         @(posedge clock_in);
         ack_on <= 1'b0;
      end
      if (hung) wrap_up();
   endtask
   task automatic ret();
      @(posedge clock_in);
      reti_go <= 1'b1;
      @(posedge clock_in);
      reti_go <= 1'b0;
   endtask
   task automatic set_src(input int k, input logic v);
      @(posedge clock_in);
      case (k)
         0: pin0 <= ~v;
         1: t0ov <= v;
         2: pin1 <= ~v;
         3: t1ov <= v;
         5: t2ov <= v;
         default: u1rx <= v;
      endcase
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge clock_in);
      {pd_trig, ext_trig} <= v;
      @(posedge clock_in);
      {pd_trig, ext_trig} <= 5'h00;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #2 clock_in = ~clock_in;
   end
   initial begin
      int i, k, p;
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 16; i++) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].r);
         check("baud", {7'h00, rows[i].b}, {7'h00, baud});
      end
      for (i = 0; i < 6; i++) begin
         k = srcs[i];
         p = (k == 0) ? 1 : 0;
         set_src(k, 1'b1);
         wr(ADDR_ENABLE_MAIN, 8'h01 << k);
         no_req(12);
         wr(ADDR_ENABLE_MAIN, 8'hEF & ~(8'h01 << k));
         no_req(12);
         wr(ADDR_ENABLE_MAIN, 8'h00);
         set_src(p, 1'b1);
         wr(ADDR_PRIO_MAIN, 8'h01 << k);
         wr(ADDR_ENABLE_MAIN, 8'h80 | (8'h01 << k) | (8'h01 << p));
         take(4'(k), 1'b1);
         no_req(12);
         set_src(k, 1'b0);
         ret();
         take(4'(p), 1'b0);
         set_src(p, 1'b0);
         ret();
         wr(ADDR_ENABLE_MAIN, 8'h00);
      end
      wr(ADDR_PRIO_MAIN, 8'h00);
      set_src(3, 1'b1);
      set_src(1, 1'b1);
      wr(ADDR_ENABLE_MAIN, 8'hCA);
      take(4'd1, 1'b0);
      set_src(1, 1'b0);
      no_req(12);
      wr(ADDR_PRIO_MAIN, 8'h40);
      @(posedge clock_in);
      u1tx <= 1'b1;
      take(4'd6, 1'b1);
      u1tx <= 1'b0;
      ret();
      ret();
      take(4'd3, 1'b0);
      set_src(3, 1'b0);
      ret();
      wr(ADDR_ENABLE_MAIN, 8'h80);
      wr(ADDR_ENABLE_EXT, 8'h0E);
      pulse(5'h01);
      no_req(12);
      wr(ADDR_EXT_FLAGS, 8'h00);
      wr(ADDR_ENABLE_EXT, 8'h0F);
      for (i = 0; i < 4; i++) begin
         pulse(5'h01 << i);
         take(4'(8 + i), 1'b0);
         rd(ADDR_EXT_FLAGS, (8'h10 << i) | 8'h08);
         wr(ADDR_EXT_FLAGS, 8'h00);
         ret();
         wr(ADDR_EXT_FLAGS, 8'h10 << i);
         take(4'(8 + i), 1'b0);
         wr(ADDR_EXT_FLAGS, 8'h00);
         ret();
      end
      wr(ADDR_ENABLE_EXT, 8'h10);
      pulse(5'h10);
      take(4'd12, 1'b0);
      ret();
      take(4'd12, 1'b0);
      wr(ADDR_EXT_CONTROL, 8'h00);
      ret();
      no_req(12);
      wr(ADDR_EXT_CONTROL, 8'h08);
      take(4'd12, 1'b0);
      wr(ADDR_EXT_CONTROL, 8'h00);
      ret();
      @(posedge clock_in);
      run <= 1'b0;
      t0ov <= 1'b1;
      wr(ADDR_ENABLE_MAIN, 8'h82);
      no_req(12);
      @(posedge clock_in);
      run <= 1'b1;
      take(4'd1, 1'b0);
      t0ov <= 1'b0;
      ret();
      @(posedge clock_in);
      edge1 <= 1'b1;
      wr(ADDR_ENABLE_MAIN, 8'h84);
      @(posedge clock_in);
      pin1 <= 1'b0;
      take(4'd2, 1'b0);
      ret();
      no_req(12);
      wr(ADDR_EXT_CONTROL, 8'h80);
      pin1 <= 1'b1;
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'b1;
      rd(ADDR_ENABLE_MAIN, 8'h00);
      check("rst baud", 8'h00, {7'h00, baud});
      rd(ADDR_EXT_CONTROL, 8'h40);
      wrap_up();
   end
endmodule
